//--- pkg/rup_pkg.sv
// Constants, states and carrier types of the serial port
package rup_pkg;
    // Register offsets on address lines 2..0
    localparam logic [2:0] OFS_DATA = 3'h0;
    localparam logic [2:0] OFS_DIVH = 3'h1;
    localparam logic [2:0] OFS_IID = 3'h2;
    localparam logic [2:0] OFS_FMT = 3'h3;
    localparam logic [2:0] OFS_HSK = 3'h4;
    localparam logic [2:0] OFS_LST = 3'h5;
    // Frame format control fields
    localparam int FMT_STOP = 2;
    localparam int FMT_PAR_EN = 3;
    localparam int FMT_EVEN = 4;
    localparam int FMT_STICK = 5;
    localparam int FMT_BREAK = 6;
    localparam int FMT_DLS = 7;
    // Handshake control fields
    localparam int HSK_RTS = 1;
    localparam int HSK_LOOP = 4;
    // Link state fields
    localparam int LST_DR = 0;
    localparam int LST_THRE = 5;
    // Interrupt source codes
    localparam logic [7:0] IID_NONE = 8'h01;
    localparam logic [7:0] IID_THRE = 8'h02;
    localparam logic [7:0] IID_RXA = 8'h04;
    localparam logic [7:0] IID_LINE = 8'h06;
    // Reset values
    localparam logic [7:0] FMT_RST = 8'h00;
    localparam logic [7:0] HSK_RST = 8'h00;
    localparam logic [15:0] DIV_RST = 16'h000C;
    // Clock rates and baud generator
    localparam int CLK_HZ = 20000000;
    localparam int XTAL_HZ = 3686400;
    localparam int XACC_W = 25;
    localparam logic [XACC_W:0] XTAL_INC = (XACC_W + 1)'(XTAL_HZ);
    localparam logic [XACC_W:0] CLK_MOD = (XACC_W + 1)'(CLK_HZ);
    // Sample ticks, sixteen per bit
    localparam logic [5:0] BIT_LAST = 6'h0F;
    localparam logic [5:0] HALF_LAST = 6'h07;
    localparam logic [5:0] STOP1_TICKS = 6'h10;
    localparam logic [5:0] STOP15_TICKS = 6'h18;
    localparam logic [5:0] STOP2_TICKS = 6'h20;
    localparam int RX_DEPTH = 4;
    typedef enum logic [4:0] {TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04,
        TX_PAR = 5'h08, TX_STOP = 5'h10} rup_txst_t;
    typedef enum logic [4:0] {RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04,
        RX_PAR = 5'h08, RX_STOP = 5'h10} rup_rxst_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } rup_hreq_t;
    typedef struct packed {
        logic brk;
        logic frameErr;
        logic parErr;
        logic [7:0] data;
    } rup_rxchar_t;
endpackage

//--- design/rup_fifo.sv
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/100ps
module rup_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock, reset and enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Filling side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Draining side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] wrPtr_q;
    logic [PW-1:0] rdPtr_q;
    logic [PW:0] count_q;
    logic push;
    logic pop;
    assign inReady = count_q != (PW + 1)'(DEPTH);
    assign outValid = count_q != '0;
    assign outData = mem_q[rdPtr_q];
    assign push = ce && inValid && inReady;
    assign pop = ce && outValid && outReady;
    always_ff @(posedge clk)
    begin
        if (push)
            mem_q[wrPtr_q] <= inData;
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end
        else
        begin
            if (push)
                wrPtr_q <= (wrPtr_q == PW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
            if (pop)
                rdPtr_q <= (rdPtr_q == PW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
            case ({push, pop})
                2'b10: count_q <= count_q + 1'b1;
                2'b01: count_q <= count_q - 1'b1;
                default: count_q <= count_q;
            endcase
        end
    end
endmodule // rup_fifo

//--- design/rup_port.sv
// Serial port core: byte registers, baud generator, transmitter, receiver
`timescale 1ns/100ps
module rup_port (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Host register port
    input wire rup_pkg::rup_hreq_t hostReq,
    output logic [7:0] rdData_q,
    // Serial line
    input wire logic rxLine,
    output logic txLine_q,
    output logic drvEn_q,
    output logic rtsOut
);
    import rup_pkg::*;

    logic [7:0] fmt_q;
    logic [7:0] hsk_q;
    logic [15:0] div_q;
    logic dls;
    logic loop;
    logic hWrData;
    logic hRdData;
    logic [2:0] lastIdx;
    logic [7:0] lenMask;
    logic [5:0] stopTicks;
    assign dls = fmt_q[FMT_DLS];
    assign loop = hsk_q[HSK_LOOP];
    assign rtsOut = hsk_q[HSK_RTS];
    assign hWrData = ce && hostReq.wr && hostReq.addr == OFS_DATA && !dls;
    assign hRdData = ce && hostReq.rd && hostReq.addr == OFS_DATA && !dls;
    assign lastIdx = 3'(fmt_q[1:0]) + 3'h4;
    assign lenMask = 8'hFF >> (2'h3 - fmt_q[1:0]);
    assign stopTicks = !fmt_q[FMT_STOP] ? STOP1_TICKS :
        (fmt_q[1:0] == 2'h0 ? STOP15_TICKS : STOP2_TICKS);

    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    function automatic logic parBit(input logic [7:0] d);
        if (fmt_q[FMT_STICK])
            return !fmt_q[FMT_EVEN];
        return (^(d & lenMask)) ^ !fmt_q[FMT_EVEN];
    endfunction

    // Register writes
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fmt_q <= FMT_RST;
            hsk_q <= HSK_RST;
            div_q <= DIV_RST;
        end
        else if (ce && hostReq.wr)
        begin
            case (hostReq.addr)
                OFS_DATA:
                    if (dls)
                        div_q[7:0] <= hostReq.wdata;
                OFS_DIVH:
                    if (dls)
                        div_q[15:8] <= hostReq.wdata;
                OFS_FMT: fmt_q <= hostReq.wdata;
                OFS_HSK: hsk_q <= hostReq.wdata;
                default: fmt_q <= fmt_q;
            endcase
        end
    end

    property p_div_low;
        ce && hostReq.wr && hostReq.addr == OFS_DATA && dls
            |=> div_q[7:0] == $past(hostReq.wdata);
    endproperty
    a_div_low: assert property (p_div_low) else $error("divisor low not loaded");
    property p_div_high;
        ce && hostReq.wr && hostReq.addr == OFS_DIVH && dls
            |=> div_q[15:8] == $past(hostReq.wdata);
    endproperty
    a_div_high: assert property (p_div_high) else $error("divisor high not loaded");

    // Baud generator: crystal-rate pulses, then sixteen ticks per bit
    logic [XACC_W-1:0] xAcc_q;
    logic [XACC_W:0] xSum;
    logic xPulse_q;
    logic [16:0] divCnt_q;
    logic smpTick_q;
    assign xSum = {1'b0, xAcc_q} + XTAL_INC;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            xAcc_q <= '0;
            xPulse_q <= 1'b0;
        end
        else if (ce)
        begin
            xPulse_q <= xSum >= CLK_MOD;
            xAcc_q <= XACC_W'(xSum >= CLK_MOD ? xSum - CLK_MOD : xSum);
        end
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            divCnt_q <= '0;
            smpTick_q <= 1'b0;
        end
        else if (ce)
        begin
            smpTick_q <= 1'b0;
            if (xPulse_q && div_q != 16'h0000)
            begin
                if (divCnt_q >= {div_q, 1'b0} - 17'h00001)
                begin
                    divCnt_q <= '0;
                    smpTick_q <= 1'b1;
                end
                else
                    divCnt_q <= divCnt_q + 17'h00001;
            end
        end
    end

    // Transmit holding register and empty event
    rup_txst_t txSt_q;
    logic [7:0] thr_q;
    logic thrFull_q;
    logic thrEvt_q;
    logic txLoad;
    logic iidRd;
    logic [7:0] iid;
    assign txLoad = ce && smpTick_q && txSt_q == TX_IDLE && thrFull_q;
    assign iidRd = ce && hostReq.rd && hostReq.addr == OFS_IID;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            thr_q <= 8'h00;
            thrFull_q <= 1'b0;
            thrEvt_q <= 1'b0;
        end
        else
        begin
            if (hWrData)
                thr_q <= hostReq.wdata;
            if (hWrData)
                thrFull_q <= 1'b1;
            else if (txLoad)
                thrFull_q <= 1'b0;
            if (txLoad)
                thrEvt_q <= 1'b1;
            else if (hWrData || (iidRd && iid == IID_THRE))
                thrEvt_q <= 1'b0;
        end
    end

    property p_thre;
        hWrData && !thrFull_q |=> thrFull_q && !thrEvt_q;
    endproperty
    a_thre: assert property (p_thre) else $error("holding empty after write");

    // Transmitter
    logic [7:0] txSh_q;
    logic txPar_q;
    logic [5:0] txCnt_q;
    logic [2:0] txIdx_q;
    logic txSer;
    logic loopSer_q;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            txSt_q <= TX_IDLE;
            txSh_q <= 8'h00;
            txPar_q <= 1'b0;
            txCnt_q <= 6'h00;
            txIdx_q <= 3'h0;
        end
        else if (ce && smpTick_q)
        begin
            txCnt_q <= txCnt_q + 6'h01;
            case (txSt_q)
                TX_IDLE:
                    if (thrFull_q)
                    begin
                        txSt_q <= TX_START;
                        txSh_q <= thr_q & lenMask;
                        txPar_q <= parBit(thr_q);
                        txCnt_q <= 6'h00;
                    end
                TX_START:
                    if (txCnt_q == BIT_LAST)
                    begin
                        txSt_q <= TX_DATA;
                        txCnt_q <= 6'h00;
                        txIdx_q <= 3'h0;
                    end
                TX_DATA:
                    if (txCnt_q == BIT_LAST)
                    begin
                        txCnt_q <= 6'h00;
                        txSh_q <= txSh_q >> 1;
                        txIdx_q <= txIdx_q + 3'h1;
                        if (txIdx_q == lastIdx)
                            txSt_q <= fmt_q[FMT_PAR_EN] ? TX_PAR : TX_STOP;
                    end
                TX_PAR:
                    if (txCnt_q == BIT_LAST)
                    begin
                        txSt_q <= TX_STOP;
                        txCnt_q <= 6'h00;
                    end
                TX_STOP:
                    if (txCnt_q == stopTicks - 6'h01)
                        txSt_q <= TX_IDLE;
                default: txSt_q <= TX_IDLE;
            endcase
        end
    end
    always_comb
    begin
        case (txSt_q)
            TX_START: txSer = 1'b0;
            TX_DATA: txSer = txSh_q[0];
            TX_PAR: txSer = txPar_q;
            default: txSer = 1'b1;
        endcase
    end
    // Line outputs; loopback keeps the pair idle and the driver off
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            txLine_q <= 1'b1;
            drvEn_q <= 1'b0;
            loopSer_q <= 1'b1;
        end
        else if (ce)
        begin
            txLine_q <= loop || (txSer && !fmt_q[FMT_BREAK]);
            drvEn_q <= !loop && (txSt_q != TX_IDLE || fmt_q[FMT_BREAK]);
            loopSer_q <= txSer && !fmt_q[FMT_BREAK];
        end
    end

    sequence s_txgo;
        txLoad && !loop ##1 txSt_q == TX_START;
    endsequence
    property p_drv;
        s_txgo ##1 !loop |-> drvEn_q;
    endproperty
    a_drv: assert property (p_drv) else $error("driver not enabled for send");
    property p_loop;
        loop && ce |=> txLine_q && !drvEn_q;
    endproperty
    a_loop: assert property (p_loop) else $error("line driven in loopback");
    property p_stop15;
        fmt_q[2:0] == 3'b100 && $fell(txSt_q == TX_STOP)
            |-> $past(txCnt_q) == STOP15_TICKS - 6'h01;
    endproperty
    a_stop15: assert property (p_stop15) else $error("stop not one and a half");
    property p_stop2;
        fmt_q[2:0] == 3'b111 && $fell(txSt_q == TX_STOP)
            |-> $past(txCnt_q) == STOP2_TICKS - 6'h01;
    endproperty
    a_stop2: assert property (p_stop2) else $error("stop not two bits");
    property p_parity;
        txLoad && !fmt_q[FMT_STICK] |=>
            txPar_q == ((^($past(thr_q) & $past(lenMask))) ^ !$past(fmt_q[FMT_EVEN]));
    endproperty
    a_parity: assert property (p_parity) else $error("wrong parity bit");
    property p_stick;
        txLoad && fmt_q[FMT_STICK] |=> txPar_q == !$past(fmt_q[FMT_EVEN]);
    endproperty
    a_stick: assert property (p_stick) else $error("stick parity wrong");

    // Receiver
    rup_rxst_t rxSt_q;
    logic rxIn;
    logic [5:0] rxCnt_q;
    logic [2:0] rxIdx_q;
    logic [7:0] rxSh_q;
    logic rxPe_q;
    logic rxPush_q;
    rup_rxchar_t rxChar_q;
    assign rxIn = loop ? loopSer_q : rxLine;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rxSt_q <= RX_IDLE;
            rxCnt_q <= 6'h00;
            rxIdx_q <= 3'h0;
            rxSh_q <= 8'h00;
            rxPe_q <= 1'b0;
            rxPush_q <= 1'b0;
            rxChar_q <= '0;
        end
        else if (ce)
        begin
            rxPush_q <= 1'b0;
            if (smpTick_q)
            begin
                rxCnt_q <= rxCnt_q + 6'h01;
                case (rxSt_q)
                    RX_IDLE:
                        if (!rxIn)
                        begin
                            rxSt_q <= RX_START;
                            rxCnt_q <= 6'h00;
                        end
                    RX_START:
                        if (rxCnt_q == HALF_LAST)
                        begin
                            rxSt_q <= rxIn ? RX_IDLE : RX_DATA;
                            rxCnt_q <= 6'h00;
                            rxIdx_q <= 3'h0;
                            rxSh_q <= 8'h00;
                            rxPe_q <= 1'b0;
                        end
                    RX_DATA:
                        if (rxCnt_q == BIT_LAST)
                        begin
                            rxCnt_q <= 6'h00;
                            rxSh_q[rxIdx_q] <= rxIn;
                            rxIdx_q <= rxIdx_q + 3'h1;
                            if (rxIdx_q == lastIdx)
                                rxSt_q <= fmt_q[FMT_PAR_EN] ? RX_PAR : RX_STOP;
                        end
                    RX_PAR:
                        if (rxCnt_q == BIT_LAST)
                        begin
                            rxSt_q <= RX_STOP;
                            rxCnt_q <= 6'h00;
                            rxPe_q <= rxIn != parBit(rxSh_q);
                        end
                    RX_STOP:
                        if (rxCnt_q == BIT_LAST)
                        begin
                            rxSt_q <= RX_IDLE;
                            rxPush_q <= 1'b1;
                            rxChar_q.brk <= !rxIn && rxSh_q == 8'h00;
                            rxChar_q.frameErr <= !rxIn;
                            rxChar_q.parErr <= rxPe_q;
                            rxChar_q.data <= rxSh_q;
                        end
                    default: rxSt_q <= RX_IDLE;
                endcase
            end
        end
    end

    // Receive buffer; a full buffer drops the character as an overrun
    logic rxRdy;
    logic rxValid;
    rup_rxchar_t rxHead;
    rup_fifo #(
        .WIDTH($bits(rup_rxchar_t)),
        .DEPTH(RX_DEPTH)
    ) u_rxFifo (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .inValid(rxPush_q),
        .inReady(rxRdy),
        .inData(rxChar_q),
        .outValid(rxValid),
        .outReady(hRdData),
        .outData(rxHead)
    );

    // Sticky line errors {break, framing, parity, overrun}; set beats read-clear
    logic [3:0] lsrErr_q;
    logic [3:0] lsrSet;
    logic [7:0] lsr;
    assign lsrSet = {4{rxPush_q}} &
        {rxChar_q.brk, rxChar_q.frameErr, rxChar_q.parErr, !rxRdy};
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            lsrErr_q <= 4'h0;
        else if (ce)
            lsrErr_q <= (hostReq.rd && hostReq.addr == OFS_LST ? 4'h0 : lsrErr_q) | lsrSet;
    end
    assign lsr = {1'b0, !thrFull_q && txSt_q == TX_IDLE, !thrFull_q, lsrErr_q, rxValid};
    assign iid = lsrErr_q != 4'h0 ? IID_LINE : rxValid ? IID_RXA :
        thrEvt_q ? IID_THRE : IID_NONE;

    // Register reads, answered on the next edge
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rdData_q <= 8'h00;
        else if (ce && hostReq.rd)
        begin
            case (hostReq.addr)
                OFS_DATA: rdData_q <= dls ? div_q[7:0] : rxHead.data;
                OFS_DIVH: rdData_q <= dls ? div_q[15:8] : 8'h00;
                OFS_IID: rdData_q <= iid;
                OFS_FMT: rdData_q <= fmt_q;
                OFS_HSK: rdData_q <= hsk_q;
                OFS_LST: rdData_q <= lsr;
                default: rdData_q <= 8'h00;
            endcase
        end
    end

    property p_dr;
        ce && hostReq.rd && hostReq.addr == OFS_LST |=> rdData_q[LST_DR] == $past(rxValid);
    endproperty
    a_dr: assert property (p_dr) else $error("data ready bit wrong");
    property p_iid_none;
        iidRd && !rxValid && !thrEvt_q && lsrErr_q == 4'h0 |=> rdData_q == IID_NONE;
    endproperty
    a_iid_none: assert property (p_iid_none) else $error("no-source code wrong");
endmodule // rup_port

//--- tb/rup_node.sv
// Remote RS-485 node model that sends and receives frames on the pair
`timescale 1ns/100ps
module rup_node #(
    parameter real BIT_NS = 8680.6
) (
    // Lines from the port
    input wire logic txLine,
    input wire logic drvEn,
    // Line into the port
    output logic rxLine
);
    initial rxLine = 1'b1;
    // Start, data LSB first, optional parity, stop given in half bits
    task automatic send(input logic [7:0] d, input int len, input logic pe, input logic pb,
        input int stopHalf);
        rxLine = 1'b0;
        #(BIT_NS);
        for (int i = 0; i < len; i++)
        begin
            rxLine = d[i];
            #(BIT_NS);
        end
        if (pe)
        begin
            rxLine = pb;
            #(BIT_NS);
        end
        rxLine = 1'b1;
        #(BIT_NS * stopHalf / 2.0);
    endtask
    // Samples mid-bit; reports driver state and how long the driver was on
    task automatic recv(input int len, input logic pe, output logic [7:0] d, output logic pb,
        output logic en, output real dur);
        realtime t0;
        d = 8'h00;
        pb = 1'b0;
        @(negedge txLine);
        t0 = $realtime;
        #(BIT_NS / 2.0);
        en = drvEn;
        for (int i = 0; i < len; i++)
        begin
            #(BIT_NS);
            d[i] = txLine;
        end
        if (pe)
        begin
            #(BIT_NS);
            pb = txLine;
        end
        @(negedge drvEn);
        dur = $realtime - t0;
    endtask
endmodule // rup_node

//--- tb/rup_port_tb_top.sv
// Self-checking bench of the serial port against a frame-level model
`timescale 1ns/100ps
module rup_port_tb_top;
    import rup_pkg::*;
    localparam real BIT_NS = 32.0e9 / 3686400.0;
    logic clk;
    logic rst_n;
    logic ce;
    rup_hreq_t hostReq;
    logic [7:0] rdData_q;
    logic rxLine;
    logic txLine_q;
    logic drvEn_q;
    logic rtsOut;
    int numErrors = 0;
    int numChecks = 0;
    int cycles = 0;
    int seed = 32'h00fceab4;
    int len;
    int stopH;
    logic [7:0] rxQ[$];
    logic [7:0] v;
    logic [7:0] d;
    logic [7:0] f;
    logic [7:0] gd;
    logic pb;
    logic gp;
    logic en;
    real dur;
    logic [7:0] fmts[7] = '{8'h03, 8'h00, 8'h04, 8'h07, 8'h1B, 8'h0A, 8'h3A};

    rup_port dut_u (.clk(clk), .rst_n(rst_n), .ce(ce), .hostReq(hostReq),
        .rdData_q(rdData_q), .rxLine(rxLine), .txLine_q(txLine_q), .drvEn_q(drvEn_q),
        .rtsOut(rtsOut));
    rup_node #(.BIT_NS(BIT_NS)) node_u (.txLine(txLine_q), .drvEn(drvEn_q), .rxLine(rxLine));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic stopTest();
        $display("checks %0d errors %0d", numChecks, numErrors);
        if (numErrors == 0 && numChecks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic fail(input string what);
        numErrors++;
        $display("mismatch at %0t: %s", $time, what);
    endtask

    task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
        numChecks++;
        if (got !== exp)
            fail($sformatf("%s got %h expected %h", what, got, exp));
    endtask

    task automatic checkTime(input real got, input real exp);
        numChecks++;
        if (got < exp - BIT_NS / 4.0 || got > exp + BIT_NS / 4.0)
            fail($sformatf("driver on %0.1f ns expected %0.1f", got, exp));
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] dat);
        @(negedge clk);
        hostReq = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: dat};
        @(negedge clk);
        hostReq.wr = 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] dat);
        @(negedge clk);
        hostReq = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'($random(seed))};
        @(negedge clk);
        hostReq.rd = 1'b0;
        dat = rdData_q;
    endtask

    // Polls a register until the masked value appears
    task automatic waitReg(input logic [2:0] a, input logic [7:0] m, input logic [7:0] x);
        logic [7:0] s;
        for (int i = 0; i < 3000; i++)
        begin
            rd(a, s);
            if ((s & m) === x)
                return;
        end
        fail("poll ran out");
    endtask

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 80000)
        begin
            fail("timeout");
            stopTest();
        end
    end

    initial
    begin
        ce = 1'b1;
        rst_n = 1'b0;
        hostReq = '0;
        repeat (20) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        rd(OFS_LST, v);
        check8(v, 8'h60, "lst reset");
        rd(OFS_FMT, v);
        check8(v, FMT_RST, "fmt reset");
        rd(3'h7, v);
        check8(v, 8'h00, "unmapped");
        wr(OFS_FMT, 8'h80);
        rd(OFS_DATA, v);
        check8(v, DIV_RST[7:0], "div low");
        rd(OFS_DIVH, v);
        check8(v, DIV_RST[15:8], "div high");
        wr(OFS_DATA, 8'h01);
        wr(OFS_DIVH, 8'h00);
        rd(OFS_DATA, v);
        check8(v, 8'h01, "div set");
        wr(OFS_FMT, 8'h03);
        rd(OFS_DATA, v);
        rd(OFS_DATA, v);
        rd(OFS_LST, v);
        check8(v & 8'h01, 8'h00, "flushed");
        // Request-to-send set and cleared without touching other bits
        rd(OFS_HSK, v);
        wr(OFS_HSK, v | 8'h02);
        check8({7'h00, rtsOut}, 8'h01, "rts set");
        rd(OFS_HSK, v);
        wr(OFS_HSK, v & 8'hFD);
        check8({7'h00, rtsOut}, 8'h00, "rts clear");
        // A write while the clock enable is low must be lost
        ce = 1'b0;
        wr(OFS_HSK, 8'h02);
        ce = 1'b1;
        check8({7'h00, rtsOut}, 8'h00, "ce frozen");
        // Break holds the pair low with the driver on
        wr(OFS_FMT, 8'h43);
        @(negedge clk);
        check8({6'h00, txLine_q, drvEn_q}, 8'h01, "break");
        foreach (fmts[k])
        begin
            f = fmts[k];
            len = f[1:0] + 5;
            stopH = f[2] ? (len == 5 ? 3 : 4) : 2;
            wr(OFS_FMT, f);
            d = 8'($random(seed)) & 8'((1 << len) - 1);
            pb = f[5] ? !f[4] : (f[4] ? ^d : ~^d);
            wr(OFS_DATA, d);
            node_u.recv(len, f[3], gd, gp, en, dur);
            check8(gd, d, "tx data");
            check8(f[3] ? gp : 1'b0, f[3] ? pb : 1'b0, "tx parity");
            check8({7'h00, en}, 8'h01, "driver");
            checkTime(dur, (1.0 + len + f[3] + stopH / 2.0) * BIT_NS * 1.0);
            d = 8'($random(seed)) & 8'((1 << len) - 1);
            rxQ.push_back(d);
            pb = f[5] ? !f[4] : (f[4] ? ^d : ~^d);
            @(negedge clk);
            node_u.send(d, len, f[3], pb, stopH);
            waitReg(OFS_LST, 8'h01, 8'h01);
            rd(OFS_IID, v);
            check8(v, IID_RXA, "iid data");
            rd(OFS_DATA, v);
            check8(v, rxQ.pop_front(), "rx data");
        end
        // Loopback: five characters into a four-deep buffer
        wr(OFS_FMT, 8'h03);
        wr(OFS_HSK, 8'h10);
        for (int i = 0; i < 5; i++)
        begin
            d = 8'($random(seed));
            if (i < 4)
                rxQ.push_back(d);
            waitReg(OFS_LST, 8'h20, 8'h20);
            wr(OFS_DATA, d);
            check8({6'h00, txLine_q, drvEn_q}, 8'h02, "loop line");
        end
        waitReg(OFS_IID, 8'hFF, IID_LINE);
        rd(OFS_LST, v);
        check8(v & 8'h1F, 8'h03, "overrun");
        repeat (4)
        begin
            rd(OFS_DATA, v);
            check8(v, rxQ.pop_front(), "loop data");
        end
        rd(OFS_LST, v);
        check8(v & 8'h01, 8'h00, "drained");
        rd(OFS_IID, v);
        check8(v, IID_THRE, "iid holding");
        rd(OFS_IID, v);
        check8(v, IID_NONE, "iid none");
        stopTest();
    end
endmodule // rup_port_tb_top
